// [fmsp_pkg.sv]
// =====================================================================
// Shared constants and types of the four mode serial port
package fmsp_pkg;

    // =================================================================
    // Register addresses and reset values on the special function register port
    localparam logic [7:0] SCTL_ADDR = 8'h98;
    localparam logic [7:0] BUF_ADDR = 8'h99;
    localparam logic [7:0] SCTL_RESET = 8'h00;
    localparam logic [7:0] BUF_RESET = 8'h00;

    // =================================================================
    // Mode field encodings
    localparam logic [1:0] MODE_SHIFT = 2'h0;
    localparam logic [1:0] MODE_ASYNC8 = 2'h1;
    localparam logic [1:0] MODE_ASYNC9_FIXED = 2'h2;
    localparam logic [1:0] MODE_ASYNC9_TIMER = 2'h3;

    // =================================================================
    // Rate constants
    localparam int M0_DIV = 12;
    localparam logic [2:0] M0_HALF_LAST = 3'(M0_DIV / 2 - 1);
    localparam logic [1:0] M2_OS_LAST_FAST = 2'h1;
    localparam logic [1:0] M2_OS_LAST_SLOW = 2'h3;
    localparam logic [3:0] OS_LAST = 4'hf;
    localparam logic [3:0] OS_CENTRE = 4'h7;

    // =================================================================
    // Frame lengths, counted as the index of the last bit
    localparam logic [2:0] M0_LAST_BIT = 3'h7;
    localparam logic [3:0] STOP_IDX_10BIT = 4'h9;
    localparam logic [3:0] STOP_IDX_11BIT = 4'ha;

    // =================================================================
    // Carriers
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fmsp_sfr_req_t;

    // Field order matches the control register from bit 7 down to bit 0
    typedef struct packed {
        logic mode_select_high;
        logic mode_select_low;
        logic multiproc_filter_enable;
        logic rx_enable;
        logic tx_ninth_bit;
        logic rx_ninth_bit;
        logic tx_done_flag;
        logic rx_done_flag;
    } fmsp_ctrl_t;

    typedef enum logic {
        RX_IDLE,
        RX_FRAME
    } fmsp_rx_state_t;

endpackage : fmsp_pkg

// [fmsp_baud.sv]
`timescale 1ns/100ps
// =====================================================================
// Rate enables: half bit of the shift mode and 16x oversample tick
module fmsp_baud (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic [1:0] mode_in,
    input wire logic baud_doubler_in,
    input wire logic timer_ovf_in,
    output logic m0_tick_out,
    output logic os_tick_out
);
    logic [2:0] m0_cnt;
    logic [1:0] m2_cnt;
    logic ovf_half;
    wire logic m0_wrap;
    wire logic [1:0] m2_last;
    wire logic m2_wrap;
    wire logic timer_mode;
    wire logic timer_tick;

    // =================================================================
    // Divider decode
    assign m0_wrap = (m0_cnt == fmsp_pkg::M0_HALF_LAST); // see R2
    assign m2_last = baud_doubler_in ? fmsp_pkg::M2_OS_LAST_FAST
                                     : fmsp_pkg::M2_OS_LAST_SLOW; // see R22
    assign m2_wrap = (m2_cnt == m2_last);
    assign timer_mode = mode_in[0];
    // Without doubling, every second overflow counts: rate = ovf*2^d/32
    assign timer_tick = timer_ovf_in & (baud_doubler_in | ovf_half); // see R20

    // Counters run free so the enables need no start handshake
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            m0_cnt <= 3'h0;
            m2_cnt <= 2'h0;
            ovf_half <= 1'b0;
        end else begin
            m0_cnt <= m0_wrap ? 3'h0 : m0_cnt + 3'h1;
            m2_cnt <= m2_wrap ? 2'h0 : m2_cnt + 2'h1;
            if (timer_ovf_in) begin
                ovf_half <= ~ovf_half;
            end
        end
    end

    // Registered enables, one clock wide
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            m0_tick_out <= 1'b0;
            os_tick_out <= 1'b0;
        end else begin
            m0_tick_out <= m0_wrap;
            os_tick_out <= timer_mode ? timer_tick : m2_wrap; // see R16
        end
    end

endmodule : fmsp_baud

// [fmsp_top.sv]
`timescale 1ns/100ps
// Summary of operation
// R1: Finished received bytes go to a holding register; next frame may start.
// R2: Mode field picks shift/12, async 8-bit timer, 9-bit clock/32or64, 9-bit timer.
// R3: Shift mode: device drives shift clock on transmit pin, data on receive pin.
// R4: Writing the serial buffer starts sending that byte in every mode.
// R5: Shift mode sends 8 bits LSB first, transmit-done at end of bit eight.
// R6: Shift mode receive starts only with receive accept set and done clear.
// R7: Shift mode receive-done sets one cycle after bit eight; waits for clear.
// R8: Mode 1 frame: start, 8 data bits LSB first, stop; ten bits total.
// R9: Async modes set transmit-done at the start of the stop bit.
// R10: Async receiver takes a start bit any time receive accept is set.
// R11: Mode 1 loads byte and stop bit if done clear and filter passes.
// R12: Mode 2 frame: start, 8 data bits, programmable ninth bit, stop.
// R13: Modes 2 and 3 send the transmit ninth bit field as bit nine.
// R14: Software sets the transmit ninth bit before each send as needed.
// R15: Modes 2 and 3 ignore stop; load if done clear and ninth passes filter.
// R16: Mode 3 is mode 2 framing with the timer overflow bit rate.
// R17: Shift mode leaves received ninth bit alone; filter bit has no effect.
// R18: Interrupt request rises when either done flag is set and enabled.
// R19: Hardware only sets done flags; software clears them by writing 0.
// R20: Timer rate is overflow rate times two to the doubler, over 32.
// R21: One enable gates both flag requests; software reads flags for source.
// R22: Mode 2 divides by 32 with doubler set, by 64 with it clear.
// R23: Async receiver finds start on falling edge, samples bit centres by 16x.
module fmsp_top (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire fmsp_pkg::fmsp_sfr_req_t sfr_req_in,
    input wire logic timer_ovf_in,
    input wire logic baud_doubler_in,
    input wire logic serial_irq_enable_in,
    input wire logic rxd_in,
    output logic [7:0] sfr_rdata_out,
    output logic rxd_out,
    output logic rxd_oe_out,
    output logic txd_out,
    output logic irq_out
);
    // =================================================================
    // State
    fmsp_pkg::fmsp_ctrl_t ctrl;
    logic [7:0] rx_hold;
    logic rx_meta;
    logic rx_sync;
    logic rx_prev;
    logic m0_active;
    logic m0_rx;
    logic m0_phase;
    logic [2:0] m0_cnt;
    logic [7:0] m0_shift;
    logic m0_pend;
    logic tx_active;
    logic [10:0] tx_shift;
    logic [3:0] tx_bit;
    logic [3:0] tx_sub;
    fmsp_pkg::fmsp_rx_state_t rx_state;
    logic [3:0] rx_sub;
    logic [3:0] rx_bit;
    logic [9:0] rx_shift;
    wire logic m0_tick;
    wire logic os_tick;

    // =================================================================
    // Rate enables
    fmsp_baud u_baud (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .mode_in({ctrl.mode_select_high, ctrl.mode_select_low}),
        .baud_doubler_in(baud_doubler_in),
        .timer_ovf_in(timer_ovf_in),
        .m0_tick_out(m0_tick),
        .os_tick_out(os_tick)
    );

    // =================================================================
    // Register port decode
    wire logic [1:0] mode = {ctrl.mode_select_high, ctrl.mode_select_low};
    wire logic is_m0 = (mode == fmsp_pkg::MODE_SHIFT);
    wire logic wr_ctrl = sfr_req_in.wr &&
                         (sfr_req_in.addr == fmsp_pkg::SCTL_ADDR);
    wire logic wr_buf = sfr_req_in.wr &&
                        (sfr_req_in.addr == fmsp_pkg::BUF_ADDR);
    wire logic [7:0] rd_mux =
        (sfr_req_in.addr == fmsp_pkg::SCTL_ADDR) ? ctrl :
        (sfr_req_in.addr == fmsp_pkg::BUF_ADDR) ? rx_hold : 8'h00;
    wire logic [7:0] next_sfr_rdata = sfr_req_in.rd ? rd_mux : sfr_rdata_out;

    // =================================================================
    // Shift mode sequencing
    // Start only on a tick: a short first half bit would sample stale data
    wire logic m0_rx_go = is_m0 && ctrl.rx_enable && !ctrl.rx_done_flag &&
                          !m0_active && !m0_pend && !wr_buf &&
                          m0_tick; // see R6
    wire logic m0_last = m0_tick && m0_phase && (m0_cnt == fmsp_pkg::M0_LAST_BIT);
    wire logic m0_tx_done = m0_active && !m0_rx && m0_last; // see R5
    wire logic m0_rx_done = m0_active && m0_rx && m0_last;

    // Shift mode engine; a buffer write restarts it as a transmit
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            m0_active <= 1'b0;
            m0_rx <= 1'b0;
            m0_phase <= 1'b0;
            m0_cnt <= 3'h0;
            m0_shift <= 8'h00;
            m0_pend <= 1'b0;
        end else begin
            m0_pend <= m0_rx_done; // see R7
            if (is_m0 && wr_buf) begin // see R4
                m0_active <= 1'b1;
                m0_rx <= 1'b0;
                m0_phase <= 1'b0;
                m0_cnt <= 3'h0;
                m0_shift <= sfr_req_in.wdata;
            end else if (m0_rx_go) begin
                m0_active <= 1'b1;
                m0_rx <= 1'b1;
                m0_phase <= 1'b0;
                m0_cnt <= 3'h0;
            end else if (m0_active && m0_tick) begin
                m0_phase <= ~m0_phase;
                if (m0_phase) begin // Falling edge: next bit, LSB first
                    m0_cnt <= m0_cnt + 3'h1;
                    m0_active <= !m0_last;
                    if (!m0_rx) begin
                        m0_shift <= {1'b0, m0_shift[7:1]}; // see R5
                    end
                end else if (m0_rx) begin // Sample on the rising edge
                    m0_shift <= {rx_sync, m0_shift[7:1]};
                end
            end
        end
    end

    // =================================================================
    // Asynchronous transmitter
    wire logic [3:0] tx_stop_idx = (mode == fmsp_pkg::MODE_ASYNC8) ?
        fmsp_pkg::STOP_IDX_10BIT : fmsp_pkg::STOP_IDX_11BIT; // see R8 R12
    // Mode 1 puts the stop bit where the ninth bit would be
    wire logic tx_bit9 = (mode == fmsp_pkg::MODE_ASYNC8) ? 1'b1 :
                         ctrl.tx_ninth_bit; // see R13
    wire logic tx_step = tx_active && os_tick && (tx_sub == fmsp_pkg::OS_LAST);
    wire logic tx_stop_set = tx_step &&
                             ((tx_bit + 4'h1) == tx_stop_idx); // see R9
    wire logic tx_end = tx_step && (tx_bit == tx_stop_idx);

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_active <= 1'b0;
            tx_shift <= 11'h7ff;
            tx_bit <= 4'h0;
            tx_sub <= 4'h0;
        end else if (!is_m0 && wr_buf) begin // see R4
            tx_active <= 1'b1;
            tx_shift <= {1'b1, tx_bit9, sfr_req_in.wdata, 1'b0};
            tx_bit <= 4'h0;
            tx_sub <= 4'h0;
        end else if (tx_active && os_tick) begin
            tx_sub <= tx_sub + 4'h1;
            if (tx_step) begin
                tx_bit <= tx_bit + 4'h1;
                tx_shift <= {1'b1, tx_shift[10:1]}; // see R8 R12
                tx_active <= !tx_end;
            end
        end
    end

    // =================================================================
    // Asynchronous receiver
    wire logic rx_fall = rx_prev && !rx_sync; // see R23
    wire logic rx_go = !is_m0 && ctrl.rx_enable && rx_fall &&
                       (rx_state == fmsp_pkg::RX_IDLE); // see R10
    wire logic rx_centre = (rx_state == fmsp_pkg::RX_FRAME) && os_tick &&
                           (rx_sub == fmsp_pkg::OS_CENTRE); // see R23
    wire logic rx_false = rx_centre && (rx_bit == 4'h0) && rx_sync;
    wire logic [9:0] rx_next_shift = {rx_sync, rx_shift[9:1]};
    wire logic [3:0] rx_stop_idx = (mode == fmsp_pkg::MODE_ASYNC8) ?
        fmsp_pkg::STOP_IDX_10BIT : fmsp_pkg::STOP_IDX_11BIT; // see R16
    wire logic rx_fin = rx_centre && (rx_bit == rx_stop_idx);
    // Mode 1 frame ends one bit early, so its byte sits one place higher
    wire logic [7:0] rx_byte = (mode == fmsp_pkg::MODE_ASYNC8) ?
        rx_next_shift[8:1] : rx_next_shift[7:0];
    wire logic rx_ninth = (mode == fmsp_pkg::MODE_ASYNC8) ?
        rx_next_shift[9] : rx_next_shift[8]; // see R11 R15
    wire logic rx_accept = rx_fin && !ctrl.rx_done_flag &&
        (!ctrl.multiproc_filter_enable || rx_ninth); // see R11 R15

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rx_state <= fmsp_pkg::RX_IDLE;
            rx_sub <= 4'h0;
            rx_bit <= 4'h0;
            rx_shift <= 10'h000;
        end else begin
            case (rx_state)
                fmsp_pkg::RX_IDLE: begin
                    rx_sub <= 4'h0;
                    rx_bit <= 4'h0;
                    if (rx_go) begin
                        rx_state <= fmsp_pkg::RX_FRAME;
                    end
                end
                fmsp_pkg::RX_FRAME: begin
                    if (os_tick) begin
                        rx_sub <= rx_sub + 4'h1;
                    end
                    if (rx_false || rx_fin || is_m0) begin
                        rx_state <= fmsp_pkg::RX_IDLE; // Glitch, end or mode swap
                    end else if (rx_centre) begin
                        rx_bit <= rx_bit + 4'h1;
                        if (rx_bit != 4'h0) begin
                            rx_shift <= rx_next_shift;
                        end
                    end
                end
                default: begin
                    rx_state <= fmsp_pkg::RX_IDLE;
                end
            endcase
        end
    end

    // =================================================================
    // Control register and holding register
    wire logic tx_flag_set = m0_tx_done || tx_stop_set;
    wire logic rx_flag_set = m0_pend || rx_accept;
    // A hardware set in the same cycle as a software clear wins
    wire logic next_tx_flag = tx_flag_set ||
        (wr_ctrl ? sfr_req_in.wdata[1] : ctrl.tx_done_flag); // see R19
    wire logic next_rx_flag = rx_flag_set ||
        (wr_ctrl ? sfr_req_in.wdata[0] : ctrl.rx_done_flag); // see R19
    // Shift mode never touches the received ninth bit
    wire logic next_rx_ninth = rx_accept ? rx_ninth :
        (wr_ctrl ? sfr_req_in.wdata[2] : ctrl.rx_ninth_bit); // see R17

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl <= fmsp_pkg::SCTL_RESET;
            rx_hold <= fmsp_pkg::BUF_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl[7:3] <= sfr_req_in.wdata[7:3]; // see R2
            end
            ctrl.rx_ninth_bit <= next_rx_ninth;
            ctrl.tx_done_flag <= next_tx_flag;
            ctrl.rx_done_flag <= next_rx_flag;
            if (rx_accept) begin
                rx_hold <= rx_byte; // see R1 R11 R15
            end else if (m0_pend) begin
                rx_hold <= m0_shift; // see R7
            end
        end
    end

    // =================================================================
    // Pin synchroniser; the second stage and its one-cycle delayed copy are looked at
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
            rx_prev <= 1'b1;
        end else begin
            rx_meta <= rxd_in;
            rx_sync <= rx_meta;
            rx_prev <= rx_sync;
        end
    end

    // Registered outputs; receive pin is driven only while shifting out
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sfr_rdata_out <= 8'h00;
            rxd_out <= 1'b1;
            rxd_oe_out <= 1'b0;
            txd_out <= 1'b1;
            irq_out <= 1'b0;
        end else begin
            sfr_rdata_out <= next_sfr_rdata;
            rxd_out <= m0_shift[0];
            rxd_oe_out <= is_m0 && m0_active && !m0_rx; // see R3
            txd_out <= is_m0 ? (!m0_active || m0_phase) :
                       (!tx_active || tx_shift[0]); // see R3 R8
            irq_out <= serial_irq_enable_in &&
                (ctrl.tx_done_flag || ctrl.rx_done_flag); // see R18 R21
        end
    end

    // =================================================================
    // Checks
    sequence s_m0_rx_last;
        m0_rx_done;
    endsequence

    sequence s_m0_ri_follow;
        ##1 m0_pend ##1 ctrl.rx_done_flag;
    endsequence

    a_m0_tx_eight: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see R5
        (is_m0 && wr_buf && !ctrl.tx_done_flag) ##1
        (!wr_buf && !wr_ctrl && is_m0)[*8] |-> ##[80:100] ctrl.tx_done_flag)
        else $error("shift mode transmit-done not seen after eight bits");

    a_m0_rx_gate: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see R6
        ($rose(m0_active) && m0_rx) |-> $past(ctrl.rx_enable && !ctrl.rx_done_flag))
        else $error("shift mode receive began without accept");

    a_m0_ri_delay: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see R7
        s_m0_rx_last |-> s_m0_ri_follow)
        else $error("shift mode receive-done not one cycle late");

    a_tx_stop_flag: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see R9
        (!is_m0 && tx_active && $rose(ctrl.tx_done_flag) && !$past(wr_ctrl))
        |-> (tx_bit == tx_stop_idx) && tx_shift[0])
        else $error("transmit-done not at start of stop bit");

    a_tx_start_bit: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see R8
        ($rose(tx_active) && !is_m0) |=> !txd_out)
        else $error("frame did not open with a low start bit");

    a_rx_hold_kept: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see R11
        (rx_fin && ctrl.rx_done_flag) |=> $stable(rx_hold) && ctrl.rx_done_flag)
        else $error("holding register overwritten while full");

    a_rx_filter: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see R15
        (rx_fin && !ctrl.rx_done_flag && ctrl.multiproc_filter_enable &&
         !rx_ninth && !wr_ctrl && !m0_pend) |=> !ctrl.rx_done_flag)
        else $error("filtered frame set receive-done");

    a_irq_gate: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see R18
        ##1 (irq_out == $past(serial_irq_enable_in &&
             (ctrl.tx_done_flag || ctrl.rx_done_flag))))
        else $error("interrupt request does not follow flags");

    a_set_wins: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see R19
        (tx_flag_set || rx_flag_set) |=>
        (ctrl.tx_done_flag || !$past(tx_flag_set)) &&
        (ctrl.rx_done_flag || !$past(rx_flag_set)))
        else $error("hardware flag set lost to a clear");

endmodule : fmsp_top

// [fmsp_peer.sv]
`timescale 1ns/100ps
// ==========================================================
// Remote serial device: frame sender and line watcher
module fmsp_peer (
    input wire logic mclk_in,
    input wire logic txd_in,
    input wire logic pin_in,
    input wire logic probe_in,
    output logic line_out
);
    // Idle line rests high, as if pulled up
    initial line_out = 1'b1;

    // Send start, data and two trailing bits, per clocks each
    task automatic send(input logic [10:0] f, input int per);
        for (int i = 0; i < 11; i++) begin
            line_out <= f[i];
            repeat (per) @(posedge mclk_in);
        end
        line_out <= 1'b1;
    endtask : send

    // Sample eleven bit centres on the transmit pin
    task automatic grab(input int per, output logic [10:0] f,
                        output logic [10:0] p);
        @(negedge txd_in);
        repeat (per / 2) @(negedge mclk_in);
        for (int i = 0; i < 11; i++) begin
            f[i] = txd_in;
            p[i] = probe_in;
            if (i < 10)
                repeat (per) @(negedge mclk_in);
        end
    endtask : grab

    // Shift mode: take the pin at each rising shift clock
    task automatic m0_grab(output logic [7:0] d, output logic [7:0] p);
        for (int i = 0; i < 8; i++) begin
            @(posedge txd_in);
            @(negedge mclk_in);
            d[i] = pin_in;
            p[i] = probe_in;
        end
    endtask : m0_grab

    // Shift mode: new bit on each falling shift clock
    task automatic m0_feed(input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            @(negedge txd_in);
            line_out <= d[i];
        end
        @(posedge txd_in);
        repeat (3) @(posedge mclk_in);
        // Hold time over: the old value must not linger
        line_out <= ~d[7];
    endtask : m0_feed
endmodule : fmsp_peer

// [test_four_mode_serial_port.sv]
`timescale 1ns/100ps
// ==========================================================
// Self-checking bench of the four mode serial port
module test_four_mode_serial_port;
    logic mclk_in = 1'b0;
    logic rst_b_in = 1'b0;
    fmsp_pkg::fmsp_sfr_req_t req = '0;
    logic ovf = 1'b0;
    logic dbl = 1'b1;
    logic irq_en = 1'b0;
    logic [7:0] rdata, got, b8, p8;
    logic rxd_out, rxd_oe, txd, irq, line, pin, lo, nb;
    logic [10:0] fr, pr;
    int err_count = 0;
    int n_tests = 0;
    int per, st;
    logic [7:0] tx_c [6] = '{8'h40, 8'h40, 8'h88, 8'h80, 8'hc8, 8'hc0};
    logic [7:0] tx_d [6] = '{8'ha5, 8'h3c, 8'h5a, 8'h81, 8'h0f, 8'hf0};
    logic [7:0] rx_c [9] = '{8'h50, 8'h51, 8'h70, 8'h70, 8'hb0, 8'hb0,
                             8'h90, 8'hd0, 8'h90};
    logic [7:0] rx_d [9] = '{8'h3c, 8'hc3, 8'h99, 8'h77, 8'h12, 8'h34,
                             8'h56, 8'h78, 8'h9a};
    logic [7:0] rx_ec [9] = '{8'h55, 8'h51, 8'h70, 8'h75, 8'hb0, 8'hb5,
                              8'h91, 8'hd5, 8'h95};
    logic [7:0] rx_eb [9] = '{8'h3c, 8'h3c, 8'h3c, 8'h77, 8'h77, 8'h34,
                              8'h56, 8'h78, 8'h9a};
    int rx_per [9] = '{32, 32, 32, 32, 32, 32, 64, 32, 32};
    logic [8:0] rx_nb = 9'h1ab;
    logic [8:0] rx_sb = 9'h0ff;

    // Receive pin: the block drives it only with its enable up
    assign pin = rxd_oe ? rxd_out : line;

    fmsp_top dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
        .sfr_req_in(req), .timer_ovf_in(ovf), .baud_doubler_in(dbl),
        .serial_irq_enable_in(irq_en), .rxd_in(pin),
        .sfr_rdata_out(rdata), .rxd_out(rxd_out), .rxd_oe_out(rxd_oe),
        .txd_out(txd), .irq_out(irq));
    fmsp_peer peer (.mclk_in(mclk_in), .txd_in(txd), .pin_in(pin),
        .probe_in(irq), .line_out(line));

    // Clock, and an overflow pulse every second cycle
    initial forever #20 mclk_in = ~mclk_in;
    always @(posedge mclk_in) ovf <= ~ovf;

    // ======================================================
    // Register port and checking tasks
    task automatic acc(input logic w, input logic [7:0] a, d);
        @(posedge mclk_in);
        req <= '{w, !w, a, d};
        @(posedge mclk_in);
        req <= '0;
    endtask : acc

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        acc(1'b0, a, 8'h00);
        @(negedge mclk_in);
        d = rdata;
    endtask : rd

    task automatic chk(input logic [10:0] g, input logic [10:0] e);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h, want %h", $time, g, e);
        end
    endtask : chk

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up

    // Watchdog: the whole run needs far fewer cycles than this
    initial begin
        repeat (40000) @(posedge mclk_in);
        err_count++;
        wrap_up();
    end

    // ======================================================
    // Test sequence
    initial begin
        repeat (12) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        // Unmapped write is dropped, all reads give reset values
        acc(1'b1, 8'h9a, 8'hff);
        for (int a = 0; a < 3; a++) begin
            rd(8'h98 + 8'(a), got);
            chk(got, 8'h00);
        end
        // Async transmit in modes 1 to 3, both doubler settings
        irq_en <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            dbl <= (i % 2 == 0);
            per = (i % 2 == 0) ? 32 : 64;
            acc(1'b1, 8'h98, tx_c[i]);
            fork
                acc(1'b1, 8'h99, tx_d[i]);
                peer.grab(per, fr, pr);
            join
            st = tx_c[i][7] ? 10 : 9;
            nb = tx_c[i][7] ? tx_c[i][3] : 1'b1;
            chk(fr, {1'b1, nb, tx_d[i], 1'b0});
            chk({pr[st], pr[st - 1]}, 2'b10);
            repeat (per) @(posedge mclk_in);
        end
        // Async receive: accepted and refused frames
        for (int i = 0; i < 9; i++) begin
            dbl <= (rx_per[i] == 32);
            acc(1'b1, 8'h98, rx_c[i]);
            peer.send({rx_sb[i], rx_nb[i], rx_d[i], 1'b0}, rx_per[i]);
            repeat (8) @(posedge mclk_in);
            rd(8'h98, got);
            chk(got, rx_ec[i]);
            rd(8'h99, got);
            chk(got, rx_eb[i]);
        end
        // Shift mode transmit, then interrupt gating
        acc(1'b1, 8'h98, 8'h00);
        fork
            acc(1'b1, 8'h99, 8'hc6);
            peer.m0_grab(b8, p8);
        join
        chk(b8, 8'hc6);
        chk(p8, 8'h00);
        repeat (12) @(posedge mclk_in);
        rd(8'h98, got);
        chk(got, 8'h02);
        chk(irq, 1'b1);
        @(posedge mclk_in);
        irq_en <= 1'b0;
        repeat (2) @(negedge mclk_in);
        chk(irq, 1'b0);
        // Shift mode receive with filter and ninth bit preset
        fork
            acc(1'b1, 8'h98, 8'h34);
            peer.m0_feed(8'h6b);
        join
        repeat (20) @(posedge mclk_in);
        rd(8'h98, got);
        chk(got, 8'h35);
        rd(8'h99, got);
        chk(got, 8'h6b);
        // No new shift clock while the receive flag is up
        lo = 1'b0;
        repeat (120) begin
            @(negedge mclk_in);
            lo = lo | !txd;
        end
        chk(lo, 1'b0);
        wrap_up();
    end
endmodule : test_four_mode_serial_port
